// File: include/harm_stab_map.svh
// Offsets, field positions, reset values and timing for the stabiliser
`ifndef HARM_STAB_MAP_SVH
`define HARM_STAB_MAP_SVH

// Register byte offsets
`define HS_OFS_CTRL      8'h00
`define HS_OFS_BLK_SEL   8'h04
`define HS_OFS_OC_LIM    8'h08
`define HS_OFS_LIM2      8'h0C
`define HS_OFS_LIM5      8'h10
`define HS_OFS_TMAX2     8'h14
`define HS_OFS_TMAX5     8'h18
`define HS_OFS_STATUS    8'h1C

// Control field positions
`define HS_CTRL_EN_BIT   0
`define HS_CTRL_MODE_BIT 1

// Reset values: limits in 0.1 % units, times in ms
`define HS_RST_OC_LIM    16'h1D4C
`define HS_RST_LIM2      16'h0064
`define HS_RST_LIM5      16'h0064
`define HS_RST_TMAX      32'h000003E8
`define HS_RST_BLK_SEL   14'h0000

// Harmonic ratio scale: limit unit is 1/1000 of fundamental
`define HS_RATIO_SCALE   32'h000003E8

// Timing: clock period and millisecond tick derived from it
`define HS_CLK_NS        4
`define HS_MS_NS         1000000
`define HS_CYC_PER_MS    ((`HS_MS_NS + `HS_CLK_NS - 1) / `HS_CLK_NS)

`endif

// File: include/harm_stab_pkg.sv
// Types shared by the stabiliser modules
package harm_stab_pkg;

    // Measured quantity or limit, 0.1 % units
    typedef logic [15:0] meas_t;

    // Maximum blocking-time supervisor states
    typedef enum logic [2:0] {
        SUP_IDLE = 3'b001,
        SUP_RUN  = 3'b010,
        SUP_TRIP = 3'b100
    } sup_state_e;

endpackage

// File: design/harm_time_supervisor.sv
// Maximum blocking-time supervisor for one harmonic, three phases
`timescale 1ns/100ps
module harm_time_supervisor
    import harm_stab_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Qualifiers
    input  wire logic        allow_i,
    input  wire logic [2:0]  exceed_i,
    input  wire logic        ms_tick_i,
    input  wire logic [31:0] max_time_i,
    // Results
    output logic      [2:0]  block_o,
    output logic             supervised_o
);

    sup_state_e  state;
    sup_state_e  next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;

    // Next state of the time window
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (!allow_i) begin
            next_state = SUP_IDLE;
            next_cnt   = '0;
        end else if (exceed_i == 3'h0) begin
            next_state = SUP_IDLE;
            next_cnt   = '0;
        end else begin
            case (state)
                SUP_IDLE: begin
                    next_state = SUP_RUN;
                    next_cnt   = max_time_i;
                end
                SUP_RUN: begin
                    if (cnt == 32'h0) begin
                        next_state = SUP_TRIP;
                    end else if (ms_tick_i) begin
                        next_cnt = cnt - 32'h1;
                    end
                end
                SUP_TRIP: begin
                    next_state = SUP_TRIP;
                end
                default: begin
                    next_state = SUP_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= SUP_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Once tripped the blocks drop although harmonics persist
    assign supervised_o = (state == SUP_TRIP);
    assign block_o      = (allow_i && !supervised_o) ? exceed_i : 3'h0;

    sequence s_first_exceed;
        state == SUP_IDLE && allow_i && exceed_i != 3'h0;
    endsequence

    sequence s_window_loaded;
        state == SUP_RUN && cnt == $past(max_time_i);
    endsequence

    property p_window_load;
        @(posedge clk_i) disable iff (rst_i)
        s_first_exceed |=> s_window_loaded;
    endproperty
    a_window_load: assert property (p_window_load)
        else $error("window not loaded on first exceed");

    property p_expire;
        @(posedge clk_i) disable iff (rst_i)
        state == SUP_RUN && cnt == 32'h0 && allow_i && exceed_i != 3'h0
        |=> supervised_o ##0 block_o == 3'h0;
    endproperty
    a_expire: assert property (p_expire)
        else $error("supervision not raised at expiry");

    property p_sup_clear;
        @(posedge clk_i) disable iff (rst_i)
        supervised_o && exceed_i == 3'h0 |=> !supervised_o;
    endproperty
    a_sup_clear: assert property (p_sup_clear)
        else $error("supervision not cleared below limit");

endmodule

// File: design/harmonic_inrush_stabiliser.sv
// Harmonic inrush stabiliser: settings port, detection and events
`timescale 1ns/100ps
`include "harm_stab_map.svh"
module harmonic_inrush_stabiliser
    import harm_stab_pkg::*;
#(
    parameter int EVT_W      = 16,
    parameter int CYC_PER_MS = `HS_CYC_PER_MS
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Settings port
    input  wire logic [7:0]       addr_i,
    input  wire logic [31:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [31:0]      rdata_o,
    // Measurements, one value per phase
    input  wire logic             sample_i,
    input  wire meas_t [2:0]      fund_i,
    input  wire meas_t [2:0]      second_harmonic_i,
    input  wire meas_t [2:0]      fifth_harmonic_i,
    // Event bus for the external block
    input  wire logic [EVT_W-1:0] event_bus_i,
    // Module events
    output logic                  module_active_evt_o,
    output logic                  module_blocked_evt_o,
    output logic                  overcurrent_blocked_evt_o,
    // Per-phase harmonic events
    output logic                  ph1_second_block_evt_o,
    output logic                  ph2_second_block_evt_o,
    output logic                  ph3_second_block_evt_o,
    output logic                  ph1_fifth_block_evt_o,
    output logic                  ph2_fifth_block_evt_o,
    output logic                  ph3_fifth_block_evt_o,
    // Supervision events and pickup blocks
    output logic                  second_supervision_evt_o,
    output logic                  fifth_supervision_evt_o,
    output logic      [2:0]       phase_pickup_block_o
);

    // Harmonic portion above limit, limit in 1/1000 of fundamental
    function automatic logic harm_over(meas_t harm, meas_t fund,
                                       meas_t lim);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(harm) * `HS_RATIO_SCALE;
        rhs = 32'(lim) * 32'(fund);
        return (fund != 16'h0000) && (lhs > rhs);
    endfunction

    // Pick the selected event; zero or out of range selects none
    function automatic logic sel_event(logic [EVT_W-1:0] bus,
                                       logic [13:0] sel);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < EVT_W; i++) begin
            if (sel == 14'(i + 1)) begin
                hit = bus[i];
            end
        end
        return hit;
    endfunction

    // Settings state
    logic        en;
    logic        three_ph;
    logic [13:0] blk_sel;
    meas_t       oc_lim;
    meas_t       lim2;
    meas_t       lim5;
    logic [31:0] tmax2;
    logic [31:0] tmax5;
    logic        next_en;
    logic        next_three_ph;
    logic [13:0] next_blk_sel;
    meas_t       next_oc_lim;
    meas_t       next_lim2;
    meas_t       next_lim5;
    logic [31:0] next_tmax2;
    logic [31:0] next_tmax5;
    logic [31:0] next_rdata;
    logic [31:0] status;

    // Register writes; reads answer one cycle later, else zero
    always_comb begin
        next_en       = en;
        next_three_ph = three_ph;
        next_blk_sel  = blk_sel;
        next_oc_lim   = oc_lim;
        next_lim2     = lim2;
        next_lim5     = lim5;
        next_tmax2    = tmax2;
        next_tmax5    = tmax5;
        next_rdata    = 32'h0000_0000;
        if (wr_i) begin
            if (addr_i == `HS_OFS_CTRL) begin
                next_en       = wdata_i[`HS_CTRL_EN_BIT];
                next_three_ph = wdata_i[`HS_CTRL_MODE_BIT];
            end else if (addr_i == `HS_OFS_BLK_SEL) begin
                next_blk_sel = wdata_i[13:0];
            end else if (addr_i == `HS_OFS_OC_LIM) begin
                next_oc_lim = wdata_i[15:0];
            end else if (addr_i == `HS_OFS_LIM2) begin
                next_lim2 = wdata_i[15:0];
            end else if (addr_i == `HS_OFS_LIM5) begin
                next_lim5 = wdata_i[15:0];
            end else if (addr_i == `HS_OFS_TMAX2) begin
                next_tmax2 = wdata_i;
            end else if (addr_i == `HS_OFS_TMAX5) begin
                next_tmax5 = wdata_i;
            end
        end
        if (rd_i) begin
            if (addr_i == `HS_OFS_CTRL) begin
                next_rdata[`HS_CTRL_EN_BIT]   = en;
                next_rdata[`HS_CTRL_MODE_BIT] = three_ph;
            end else if (addr_i == `HS_OFS_BLK_SEL) begin
                next_rdata[13:0] = blk_sel;
            end else if (addr_i == `HS_OFS_OC_LIM) begin
                next_rdata[15:0] = oc_lim;
            end else if (addr_i == `HS_OFS_LIM2) begin
                next_rdata[15:0] = lim2;
            end else if (addr_i == `HS_OFS_LIM5) begin
                next_rdata[15:0] = lim5;
            end else if (addr_i == `HS_OFS_TMAX2) begin
                next_rdata = tmax2;
            end else if (addr_i == `HS_OFS_TMAX5) begin
                next_rdata = tmax5;
            end else if (addr_i == `HS_OFS_STATUS) begin
                next_rdata = status;
            end
        end
    end

    // Settings registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en       <= 1'b0;
            three_ph <= 1'b0;
            blk_sel  <= `HS_RST_BLK_SEL;
            oc_lim   <= `HS_RST_OC_LIM;
            lim2     <= `HS_RST_LIM2;
            lim5     <= `HS_RST_LIM5;
            tmax2    <= `HS_RST_TMAX;
            tmax5    <= `HS_RST_TMAX;
            rdata_o  <= 32'h0000_0000;
        end else begin
            en       <= next_en;
            three_ph <= next_three_ph;
            blk_sel  <= next_blk_sel;
            oc_lim   <= next_oc_lim;
            lim2     <= next_lim2;
            lim5     <= next_lim5;
            tmax2    <= next_tmax2;
            tmax5    <= next_tmax5;
            rdata_o  <= next_rdata;
        end
    end

    // Comparison state, refreshed only on the sample strobe
    logic [2:0] ex2;
    logic [2:0] ex5;
    logic       ovc;
    logic [2:0] next_ex2;
    logic [2:0] next_ex5;
    logic       next_ovc;

    always_comb begin
        next_ex2 = ex2;
        next_ex5 = ex5;
        next_ovc = ovc;
        if (sample_i) begin
            next_ovc = 1'b0;
            for (int p = 0; p < 3; p++) begin
                next_ex2[p] = harm_over(second_harmonic_i[p], fund_i[p],
                                        lim2);
                next_ex5[p] = harm_over(fifth_harmonic_i[p], fund_i[p],
                                        lim5);
                if (fund_i[p] > oc_lim) begin
                    next_ovc = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ex2 <= 3'h0;
            ex5 <= 3'h0;
            ovc <= 1'b0;
        end else begin
            ex2 <= next_ex2;
            ex5 <= next_ex5;
            ovc <= next_ovc;
        end
    end

    // Millisecond tick; the first tick after a start may come early
    logic [31:0] presc;
    logic [31:0] next_presc;
    logic        ms_tick;
    logic        next_ms_tick;

    always_comb begin
        next_ms_tick = (presc == 32'(CYC_PER_MS - 1));
        next_presc   = next_ms_tick ? 32'h0 : presc + 32'h1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc   <= 32'h0;
            ms_tick <= 1'b0;
        end else begin
            presc   <= next_presc;
            ms_tick <= next_ms_tick;
        end
    end

    // Qualification: external block and overcurrent stop stabilising
    logic       ext;
    logic       allow;
    logic [2:0] b2;
    logic [2:0] b5;
    logic       sup2;
    logic       sup5;

    assign ext   = sel_event(event_bus_i, blk_sel);
    assign allow = en && !ext && !ovc;

    harm_time_supervisor u_sup_second (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .allow_i      (allow),
        .exceed_i     (ex2),
        .ms_tick_i    (ms_tick),
        .max_time_i   (tmax2),
        .block_o      (b2),
        .supervised_o (sup2)
    );

    harm_time_supervisor u_sup_fifth (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .allow_i      (allow),
        .exceed_i     (ex5),
        .ms_tick_i    (ms_tick),
        .max_time_i   (tmax5),
        .block_o      (b5),
        .supervised_o (sup5)
    );

    // Output registers; events follow their cause one cycle later
    logic [2:0] evt2;
    logic [2:0] evt5;
    logic [2:0] next_evt2;
    logic [2:0] next_evt5;
    logic [2:0] next_pickup;

    always_comb begin
        if (three_ph) begin
            next_evt2   = {3{|b2}};
            next_evt5   = {3{|b5}};
            next_pickup = {3{|(b2 | b5)}};
        end else begin
            next_evt2   = b2;
            next_evt5   = b5;
            next_pickup = b2 | b5;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            module_active_evt_o       <= 1'b0;
            module_blocked_evt_o      <= 1'b0;
            overcurrent_blocked_evt_o <= 1'b0;
            evt2                      <= 3'h0;
            evt5                      <= 3'h0;
            second_supervision_evt_o  <= 1'b0;
            fifth_supervision_evt_o   <= 1'b0;
            phase_pickup_block_o      <= 3'h0;
        end else begin
            module_active_evt_o       <= en;
            module_blocked_evt_o      <= en && ext;
            overcurrent_blocked_evt_o <= en && !ext && ovc;
            evt2                      <= next_evt2;
            evt5                      <= next_evt5;
            // Gated by allow so an inactive module drops supervision
            second_supervision_evt_o  <= allow && sup2;
            fifth_supervision_evt_o   <= allow && sup5;
            phase_pickup_block_o      <= next_pickup;
        end
    end

    assign ph1_second_block_evt_o = evt2[0];
    assign ph2_second_block_evt_o = evt2[1];
    assign ph3_second_block_evt_o = evt2[2];
    assign ph1_fifth_block_evt_o  = evt5[0];
    assign ph2_fifth_block_evt_o  = evt5[1];
    assign ph3_fifth_block_evt_o  = evt5[2];

    // Status word for software
    assign status = {18'h0, fifth_supervision_evt_o,
                     second_supervision_evt_o, phase_pickup_block_o,
                     evt5, evt2, overcurrent_blocked_evt_o,
                     module_blocked_evt_o, module_active_evt_o};

    property p_disabled;
        @(posedge clk_i) disable iff (rst_i)
        !en |=> !module_active_evt_o && phase_pickup_block_o == 3'h0;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled module shows activity");

    property p_ext_block;
        @(posedge clk_i) disable iff (rst_i)
        en && ext |=> module_blocked_evt_o && phase_pickup_block_o == 3'h0;
    endproperty
    a_ext_block: assert property (p_ext_block)
        else $error("external block not applied");

    property p_sel_zero;
        @(posedge clk_i) disable iff (rst_i)
        blk_sel == 14'h0 |=> !module_blocked_evt_o;
    endproperty
    a_sel_zero: assert property (p_sel_zero)
        else $error("selection zero blocked the module");

    property p_ovc_set;
        @(posedge clk_i) disable iff (rst_i)
        en && !ext && ovc |=> overcurrent_blocked_evt_o;
    endproperty
    a_ovc_set: assert property (p_ovc_set)
        else $error("overcurrent event missing");

    property p_ovc_clear;
        @(posedge clk_i) disable iff (rst_i)
        $fell(ovc) |-> ##1 !overcurrent_blocked_evt_o;
    endproperty
    a_ovc_clear: assert property (p_ovc_clear)
        else $error("overcurrent event not released");

    property p_single_phase;
        @(posedge clk_i) disable iff (rst_i)
        !three_ph |=> phase_pickup_block_o == $past(b2 | b5);
    endproperty
    a_single_phase: assert property (p_single_phase)
        else $error("single-phase pickup block wrong");

    property p_three_phase;
        @(posedge clk_i) disable iff (rst_i)
        three_ph && (b2 | b5) != 3'h0 |=> phase_pickup_block_o == 3'h7;
    endproperty
    a_three_phase: assert property (p_three_phase)
        else $error("three-phase pickup block wrong");

    property p_second_evt;
        @(posedge clk_i) disable iff (rst_i)
        allow && !sup2 && !three_ph |=> evt2 == $past(ex2);
    endproperty
    a_second_evt: assert property (p_second_evt)
        else $error("second harmonic event mismatch");

    property p_fifth_evt;
        @(posedge clk_i) disable iff (rst_i)
        allow && !sup5 && !three_ph |=> evt5 == $past(ex5);
    endproperty
    a_fifth_evt: assert property (p_fifth_evt)
        else $error("fifth harmonic event mismatch");

    property p_hold_between_samples;
        @(posedge clk_i) disable iff (rst_i)
        !sample_i |=> $stable(ex2) && $stable(ex5) && $stable(ovc);
    endproperty
    a_hold_between_samples: assert property (p_hold_between_samples)
        else $error("comparison changed without sample");

    property p_inactive;
        @(posedge clk_i) disable iff (rst_i)
        !allow |=> evt2 == 3'h0 && evt5 == 3'h0 && !second_supervision_evt_o;
    endproperty
    a_inactive: assert property (p_inactive)
        else $error("blocks active while module inactive");

endmodule

// File: verification/harmonic_inrush_stabiliser_tb_top.sv
// Self-checking bench for the harmonic inrush stabiliser
`timescale 1ns/100ps
`include "harm_stab_map.svh"
module harmonic_inrush_stabiliser_tb_top
    import harm_stab_pkg::*;
;
    // Short millisecond so the time windows finish quickly
    localparam int CPM = 4;

    // Clock, reset and settings port
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic [7:0]  addr_i   = 8'h00;
    logic [31:0] wdata_i  = 32'h0;
    logic        wr_i     = 1'b0;
    logic        rd_i     = 1'b0;
    logic [31:0] rdata_o;
    // Measurements and external events
    logic        sample_i = 1'b0;
    meas_t [2:0] fund_i   = '0;
    meas_t [2:0] h2_i     = '0;
    meas_t [2:0] h5_i     = '0;
    logic [15:0] ebus_i   = 16'h0000;
    // All event outputs, packed like the status word
    wire  [13:0] evts;
    int          miscompares = 0;
    int          num_checks  = 0;

    // Free-running 250 MHz clock
    always #2 clk_i = ~clk_i;

    harmonic_inrush_stabiliser #(.CYC_PER_MS(CPM)) DUT (
        .clk_i                     (clk_i),
        .rst_i                     (rst_i),
        .addr_i                    (addr_i),
        .wdata_i                   (wdata_i),
        .wr_i                      (wr_i),
        .rd_i                      (rd_i),
        .rdata_o                   (rdata_o),
        .sample_i                  (sample_i),
        .fund_i                    (fund_i),
        .second_harmonic_i         (h2_i),
        .fifth_harmonic_i          (h5_i),
        .event_bus_i               (ebus_i),
        .module_active_evt_o       (evts[0]),
        .module_blocked_evt_o      (evts[1]),
        .overcurrent_blocked_evt_o (evts[2]),
        .ph1_second_block_evt_o    (evts[3]),
        .ph2_second_block_evt_o    (evts[4]),
        .ph3_second_block_evt_o    (evts[5]),
        .ph1_fifth_block_evt_o     (evts[6]),
        .ph2_fifth_block_evt_o     (evts[7]),
        .ph3_fifth_block_evt_o     (evts[8]),
        .second_supervision_evt_o  (evts[12]),
        .fifth_supervision_evt_o   (evts[13]),
        .phase_pickup_block_o      (evts[11:9])
    );

    // Word compare; four-state so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Event vector compare
    task automatic ev(input logic [13:0] exp);
        chk({18'h0, evts}, {18'h0, exp});
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read; data stands only in the following cycle
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // One sample: harmonics only on the phases in ph
    task automatic meas(input meas_t f, input meas_t a2, input meas_t a5,
                        input logic [2:0] ph);
        @(posedge clk_i);
        for (int p = 0; p < 3; p++) begin
            fund_i[p] <= f;
            h2_i[p]   <= ph[p] ? a2 : 16'h0000;
            h5_i[p]   <= ph[p] ? a5 : 16'h0000;
        end
        sample_i <= 1'b1;
        @(posedge clk_i);
        sample_i <= 1'b0;
        // Flags one edge after the strobe, outputs one more
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        rdchk(`HS_OFS_CTRL, 32'h0);
        rdchk(`HS_OFS_BLK_SEL, 32'h0);
        rdchk(`HS_OFS_OC_LIM, 32'h1D4C);
        rdchk(`HS_OFS_LIM2, 32'h64);
        rdchk(`HS_OFS_LIM5, 32'h64);
        rdchk(`HS_OFS_TMAX2, 32'h3E8);
        rdchk(`HS_OFS_TMAX5, 32'h3E8);
        rdchk(8'h20, 32'h0);
        meas(16'h03E8, 16'h00C8, 16'h00C8, 3'b111);
        ev(14'h0000);
        // Clear the flags so that enabling starts from no exceed
        meas(16'h03E8, 16'h0000, 16'h0000, 3'b111);
        $display("test reset done");
    endtask

    task automatic t_single();
        wr(`HS_OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk_i);
        #1;
        ev(14'h0001);
        meas(16'h03E8, 16'h0065, 16'h0000, 3'b010);
        ev(14'h0411);
        meas(16'h03E8, 16'h0064, 16'h00C8, 3'b100);
        ev(14'h0901);
        rdchk(`HS_OFS_STATUS, 32'h0901);
        // Zero fundamental must never count as an exceed
        meas(16'h0000, 16'h00C8, 16'h00C8, 3'b111);
        ev(14'h0001);
        $display("test single phase done");
    endtask

    task automatic t_three();
        wr(`HS_OFS_CTRL, 32'h3);
        meas(16'h03E8, 16'h00C8, 16'h0000, 3'b001);
        ev(14'h0E39);
        meas(16'h03E8, 16'h0000, 16'h00C8, 3'b010);
        ev(14'h0FC1);
        wr(`HS_OFS_CTRL, 32'h1);
        $display("test three phase done");
    endtask

    task automatic t_ovc();
        // Limit in tenths of percent of nominal current
        wr(`HS_OFS_OC_LIM, 32'h1D4C);
        meas(16'h1D4D, 16'h07D0, 16'h0000, 3'b001);
        ev(14'h0005);
        meas(16'h1D4C, 16'h07D0, 16'h0000, 3'b001);
        ev(14'h0209);
        $display("test overcurrent done");
    endtask

    task automatic t_ext();
        wr(`HS_OFS_BLK_SEL, 32'h3);
        @(posedge clk_i);
        ebus_i <= 16'h0004;
        meas(16'h1D4D, 16'h00C8, 16'h0000, 3'b001);
        ev(14'h0003);
        @(posedge clk_i);
        ebus_i <= 16'hFFFB;
        meas(16'h03E8, 16'h00C8, 16'h0000, 3'b001);
        ev(14'h0209);
        wr(`HS_OFS_BLK_SEL, 32'h0);
        @(posedge clk_i);
        ebus_i <= 16'hFFFF;
        meas(16'h03E8, 16'h00C8, 16'h0000, 3'b001);
        ev(14'h0209);
        @(posedge clk_i);
        ebus_i <= 16'h0000;
        $display("test external block done");
    endtask

    // Time window of one harmonic, two milliseconds long
    task automatic t_sup(input int fifth);
        int n;
        n = 0;
        // A clean sample first, so the window restarts with the new time
        meas(16'h03E8, 16'h0000, 16'h0000, 3'b111);
        wr(fifth ? `HS_OFS_TMAX5 : `HS_OFS_TMAX2, 32'h2);
        rdchk(fifth ? `HS_OFS_TMAX5 : `HS_OFS_TMAX2, 32'h2);
        meas(16'h03E8, fifth ? 16'h0 : 16'h00C8,
             fifth ? 16'h00C8 : 16'h0, 3'b001);
        ev(fifth ? 14'h0241 : 14'h0209);
        while (evts[12 + fifth] !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // Timeout counts as a mismatch; the verdict follows at the end
        if (n == 40) begin
            miscompares++;
        end
        chk({31'h0, n >= 3}, 32'h1);
        ev(fifth ? 14'h2001 : 14'h1001);
        meas(16'h03E8, 16'h0000, 16'h0000, 3'b111);
        ev(14'h0001);
        $display("test time window %0d done", fifth);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_single();
        t_three();
        t_ovc();
        t_ext();
        t_sup(0);
        t_sup(1);
        tally_and_finish();
    end
endmodule
